// File: hw/fcr_top.sv
/*
  Frame CRC check of received command frames, command category decision,
  and CRC generation for the one response frame this device sends back.
  Assumes received bytes arrive synchronous to mclk, one per valid cycle,
  with a last marker on the final CRC byte; the register engine outside
  supplies response payload bytes and executes accepted commands.
*/
`timescale 1ns/1ps
`default_nettype none

module fcr_top
  import fcr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Received command stream
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       rx_last,
  // Stack forwarding
  output logic      [7:0] fwd_data,
  output logic            fwd_valid,
  output logic            fwd_last,
  // Command result
  output logic            cmd_valid,
  output logic      [2:0] cmd_req_type,
  output logic            cmd_is_read,
  output logic            crc_err,
  // Diagnostic control
  input  wire logic       response_crc_invert,
  // Response payload from the register engine
  input  wire logic [7:0] resp_data,
  input  wire logic       resp_valid,
  input  wire logic       resp_last,
  output logic            resp_ready,
  output logic            resp_busy,
  // Response byte stream towards the host
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  output logic            tx_last,
  input  wire logic       tx_ready
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  fcr_stream_if #(.WIDTH(`FCR_FIFO_WIDTH)) push_if ();
  fcr_stream_if #(.WIDTH(`FCR_FIFO_WIDTH)) pop_if ();

  fcr_crc_t   rx_crc;
  fcr_crc_t   next_rx_crc;
  logic       rx_first;
  logic [7:0] init_q;
  logic [7:0] init_byte;
  logic [2:0] req;
  logic       frame_end;
  logic       frame_ok;
  logic       is_cmd;
  logic       start_resp;

  fcr_state_e state;
  fcr_state_e next_state;
  fcr_crc_t   tx_crc;
  fcr_crc_t   crc_out;
  logic       accept;
  logic       push_valid;
  logic [8:0] push_data;
  logic       push_free;
  logic       out_ready;

  // -----------------------------------------------------------------------
  // Receive check
  // -----------------------------------------------------------------------
  // Preset on the first byte of every frame, so a damaged frame cannot
  // poison the next one.
  assign next_rx_crc = fcr_crc_byte(rx_first ? `FCR_CRC_PRESET : rx_crc, rx_data);
  assign init_byte   = rx_first ? rx_data : init_q;
  assign req         = init_byte[`FCR_REQ_MSB:`FCR_REQ_LSB];
  assign is_cmd      = init_byte[`FCR_FRAME_TYPE_BIT];
  assign frame_end   = rx_valid && rx_last;
  assign frame_ok    = (next_rx_crc == `FCR_CRC_RESIDUE);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_crc   <= `FCR_CRC_PRESET;
      rx_first <= 1'b1;
      init_q   <= 8'h00;
    end
    else if (rx_valid)
    begin
      rx_crc   <= next_rx_crc;
      rx_first <= rx_last;
      if (rx_first)
      begin
        init_q <= rx_data;
      end
    end
  end

  // Bytes move on along the stack whatever their CRC holds.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fwd_data  <= 8'h00;
      fwd_valid <= 1'b0;
      fwd_last  <= 1'b0;
    end
    else
    begin
      fwd_valid <= rx_valid;
      fwd_last  <= frame_end;
      if (rx_valid)
      begin
        fwd_data <= rx_data;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Command decision
  // -----------------------------------------------------------------------
  // A failed frame raises only the CRC error; nothing else of it is looked
  // at, not even whether it was a command.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_valid    <= 1'b0;
      cmd_req_type <= 3'h0;
      cmd_is_read  <= 1'b0;
      crc_err      <= 1'b0;
    end
    else
    begin
      cmd_valid <= frame_end && frame_ok && is_cmd;
      crc_err   <= frame_end && !frame_ok;
      if (frame_end && frame_ok && is_cmd)
      begin
        cmd_req_type <= req;
        cmd_is_read  <= fcr_is_read(req);
      end
    end
  end

  // Only a good read command opens a response, and only from idle, so one
  // command never yields a second frame. A read arriving while the response
  // is still being assembled (resp_busy high) gets none; the host must pace its reads.
  assign start_resp = frame_end && frame_ok && is_cmd && fcr_is_read(req)
                      && (state == FCR_ST_IDLE);

  // -----------------------------------------------------------------------
  // Response sequencer
  // -----------------------------------------------------------------------
  assign accept    = resp_ready && resp_valid;
  assign push_free = !push_valid;

  always_comb
  begin
    next_state = state;
    case (state)
      FCR_ST_IDLE:
      begin
        if (start_resp)
        begin
          next_state = FCR_ST_BODY;
        end
      end
      FCR_ST_BODY:
      begin
        if (accept && resp_last)
        begin
          next_state = FCR_ST_CRC_A;
        end
      end
      FCR_ST_CRC_A:
      begin
        if (push_free)
        begin
          next_state = FCR_ST_CRC_B;
        end
      end
      FCR_ST_CRC_B:
      begin
        if (push_free)
        begin
          next_state = FCR_ST_IDLE;
        end
      end
      default:
      begin
        next_state = FCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= FCR_ST_IDLE;
      resp_busy <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      resp_busy <= (next_state != FCR_ST_IDLE);
    end
  end

  // Ready is a registered one-shot: it rises only when the push stage is
  // empty and drops after each taken byte, so no byte can overrun the
  // stage at the cost of one byte per three cycles at best.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resp_ready <= 1'b0;
    end
    else
    begin
      resp_ready <= (next_state == FCR_ST_BODY) && push_free && !accept;
    end
  end

  // -----------------------------------------------------------------------
  // Response CRC
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_crc <= `FCR_CRC_PRESET;
    end
    else if (start_resp)
    begin
      tx_crc <= `FCR_CRC_PRESET;
    end
    else if (accept)
    begin
      tx_crc <= fcr_crc_byte(tx_crc, resp_data);
    end
  end

  // Inversion is sampled as the CRC bytes leave, so flipping the control
  // in mid-frame still yields a consistent pair of bytes only if it stays.
  assign crc_out = tx_crc ^ (response_crc_invert ? `FCR_CRC_FLIP : `FCR_CRC_NOFLIP);

  // -----------------------------------------------------------------------
  // Push stage into the buffer
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      push_valid <= 1'b0;
      push_data  <= 9'h000;
    end
    else if (accept)
    begin
      push_valid <= 1'b1;
      push_data  <= {1'b0, resp_data};
    end
    else if ((state == FCR_ST_CRC_A) && push_free)
    begin
      push_valid <= 1'b1;
      push_data  <= {1'b0, crc_out[7:0]};
    end
    else if ((state == FCR_ST_CRC_B) && push_free)
    begin
      push_valid <= 1'b1;
      push_data  <= {1'b1, crc_out[15:8]};
    end
    else if (push_valid && push_if.ready)
    begin
      push_valid <= 1'b0;
    end
  end

  assign push_if.valid = push_valid;
  assign push_if.data  = push_data;

  fcr_fifo #(
    .WIDTH (`FCR_FIFO_WIDTH),
    .DEPTH (`FCR_FIFO_DEPTH)
  ) u_fifo (
    .mclk   (mclk),
    .arst_n (arst_n),
    .wr     (push_if),
    .rd     (pop_if)
  );

  // -----------------------------------------------------------------------
  // Output stage
  // -----------------------------------------------------------------------
  assign out_ready    = !tx_valid || tx_ready;
  assign pop_if.ready = out_ready;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
    end
    else if (out_ready)
    begin
      tx_valid <= pop_if.valid;
      tx_data  <= pop_if.data[7:0];
      tx_last  <= pop_if.data[8];
    end
  end

endmodule

`default_nettype wire

// File: hw/fcr_defines.svh
/*
  Constants of the frame CRC and response control block: CRC figures,
  command initialization byte fields, request type codes and buffer size.
  Assumes nothing of its surroundings; included by the package only.
*/
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH

// -----------------------------------------------------------------------
// CRC
// -----------------------------------------------------------------------
`define FCR_CRC_PRESET      16'hFFFF
`define FCR_CRC_POLY_REFL   16'hA001
`define FCR_CRC_RESIDUE     16'h0000
`define FCR_CRC_FLIP        16'hFFFF
`define FCR_CRC_NOFLIP      16'h0000

// -----------------------------------------------------------------------
// Command initialization byte
// -----------------------------------------------------------------------
`define FCR_FRAME_TYPE_BIT  7
`define FCR_REQ_MSB         6
`define FCR_REQ_LSB         4

`define FCR_REQ_SINGLE_RD   3'h0
`define FCR_REQ_SINGLE_WR   3'h1
`define FCR_REQ_STACK_RD    3'h2
`define FCR_REQ_STACK_WR    3'h3
`define FCR_REQ_BCAST_RD    3'h4
`define FCR_REQ_BCAST_WR    3'h5
`define FCR_REQ_BCAST_REV   3'h6
`define FCR_REQ_SPARE       3'h7

// -----------------------------------------------------------------------
// Response buffer
// -----------------------------------------------------------------------
`define FCR_FIFO_WIDTH      9
`define FCR_FIFO_DEPTH      16

`endif

// File: hw/fcr_pkg.sv
/*
  Types and shared functions of the frame CRC and response control block.
  Assumes fcr_defines.svh is on the include path.
*/
`include "fcr_defines.svh"

`default_nettype none

package fcr_pkg;

  typedef enum logic [2:0] {
    FCR_SINGLE_RD = `FCR_REQ_SINGLE_RD,
    FCR_SINGLE_WR = `FCR_REQ_SINGLE_WR,
    FCR_STACK_RD  = `FCR_REQ_STACK_RD,
    FCR_STACK_WR  = `FCR_REQ_STACK_WR,
    FCR_BCAST_RD  = `FCR_REQ_BCAST_RD,
    FCR_BCAST_WR  = `FCR_REQ_BCAST_WR,
    FCR_BCAST_REV = `FCR_REQ_BCAST_REV,
    FCR_SPARE     = `FCR_REQ_SPARE
  } fcr_req_e;

  typedef enum logic [3:0] {
    FCR_ST_IDLE  = 4'b0001,
    FCR_ST_BODY  = 4'b0010,
    FCR_ST_CRC_A = 4'b0100,
    FCR_ST_CRC_B = 4'b1000
  } fcr_state_e;

  typedef logic [15:0] fcr_crc_t;

  // One byte through the reflected divider, least significant bit first.
  // Shifting right with the reflected generator is the long division of
  // the bit stream with its first sixteen bits inverted by the preset and
  // the sixteen appended zeros implied by the register length.
  function automatic fcr_crc_t fcr_crc_byte(input fcr_crc_t crc, input logic [7:0] d);
    fcr_crc_t c;
    logic     fb;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[15:1]};
      if (fb)
      begin
        c = c ^ `FCR_CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  // Read category decides whether a response frame follows.
  function automatic logic fcr_is_read(input logic [2:0] req);
    logic rd;
    case (req)
      `FCR_REQ_SINGLE_RD,
      `FCR_REQ_STACK_RD,
      `FCR_REQ_BCAST_RD: rd = 1'b1;
      default:           rd = 1'b0;
    endcase
    return rd;
  endfunction

endpackage

`default_nettype wire

// File: hw/fcr_stream_if.sv
/*
  Byte stream carrier with valid and ready between the block's own modules.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface fcr_stream_if #(parameter int WIDTH = 9);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// File: hw/fcr_fifo.sv
/*
  Synchronous FIFO with parameters for width and depth, valid and ready
  on both sides. Assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module fcr_fifo
  import fcr_pkg::*;
#(
  parameter int WIDTH = `FCR_FIFO_WIDTH,
  parameter int DEPTH = `FCR_FIFO_DEPTH
)
(
  input  wire logic   mclk,
  input  wire logic   arst_n,
  fcr_stream_if.snk   wr,
  fcr_stream_if.src   rd
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  assign empty    = (wptr == rptr);
  assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr[AW-1:0]];
  assign do_wr    = wr.valid && !full;
  assign do_rd    = rd.ready && !empty;

  always_ff @(posedge mclk)
  begin
    if (do_wr)
    begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: bench/fcr_host_model.sv
/*
  Host side sink of the response byte stream with a stall control.
  Assumes the source holds tx_* until it sees tx_ready at a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module fcr_host_model
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic stall,
  input  wire logic tx_valid,
  output logic      tx_ready,
  output logic      got
);
  logic [7:0] pat;

  // Ready moves on the falling edge so the source always samples it settled;
  // the pattern mixes prompt acceptance with waits of several cycles
  always_ff @(negedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat      <= 8'hA5;
      tx_ready <= 1'b0;
    end
    else
    begin
      pat      <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
      tx_ready <= !stall && (pat[0] || pat[2]);
    end
  end

  assign got = tx_valid && tx_ready;
endmodule

`default_nettype wire

// File: bench/fcr_top_assertions.sv
/*
  Concurrent checks on the ports of fcr_top.
  Assumes the single clock mclk and the asynchronous reset arst_n.
*/
`timescale 1ns/1ps
`default_nettype none

module fcr_top_assertions
  import fcr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic [7:0] fwd_data,
  input wire logic       fwd_valid,
  input wire logic       fwd_last,
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd_req_type,
  input wire logic       cmd_is_read,
  input wire logic       crc_err,
  input wire logic       resp_valid,
  input wire logic       resp_ready,
  input wire logic       resp_busy,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_last,
  input wire logic       tx_ready
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_end;
    rx_valid && rx_last;
  endsequence
  sequence s_take;
    resp_valid && resp_ready;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence

  property p_fwd;
    rx_valid |=> fwd_valid && fwd_data == $past(rx_data);
  endproperty
  property p_fwd_last;
    s_end |=> fwd_last;
  endproperty
  property p_result;
    (cmd_valid || crc_err) |-> $past(rx_valid && rx_last);
  endproperty
  property p_excl;
    !(cmd_valid && crc_err);
  endproperty
  property p_cat;
    cmd_valid |-> cmd_is_read == (cmd_req_type inside {FCR_SINGLE_RD, FCR_STACK_RD, FCR_BCAST_RD});
  endproperty
  property p_open;
    $rose(resp_busy) |-> cmd_valid && cmd_is_read;
  endproperty
  property p_read_opens;
    cmd_valid && cmd_is_read && !$past(resp_busy) |-> resp_busy;
  endproperty
  property p_tx_hold;
    s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  property p_ready_gap;
    s_take |=> !resp_ready;
  endproperty
  property p_ready_idle;
    !resp_busy |-> !resp_ready;
  endproperty

  a_fwd:        assert property (p_fwd) else $error("forwarded byte wrong");
  a_fwd_last:   assert property (p_fwd_last) else $error("frame end not forwarded");
  a_result:     assert property (p_result) else $error("result off frame end");
  a_excl:       assert property (p_excl) else $error("command and crc error together");
  a_cat:        assert property (p_cat) else $error("wrong category");
  a_open:       assert property (p_open) else $error("response without good read");
  a_read_opens: assert property (p_read_opens) else $error("read not answered");
  a_tx_hold:    assert property (p_tx_hold) else $error("tx byte changed while stalled");
  a_ready_gap:  assert property (p_ready_gap) else $error("ready not one-shot");
  a_ready_idle: assert property (p_ready_idle) else $error("ready outside response");
endmodule

bind fcr_top fcr_top_assertions i_fcr_top_assertions
(
  .mclk, .arst_n, .rx_data, .rx_valid, .rx_last, .fwd_data, .fwd_valid, .fwd_last,
  .cmd_valid, .cmd_req_type, .cmd_is_read, .crc_err, .resp_valid, .resp_ready,
  .resp_busy, .tx_data, .tx_valid, .tx_last, .tx_ready
);

`default_nettype wire

// File: bench/frame_crc_and_response_control_test.sv
/*
  Self-checking bench of fcr_top: every request type, bad CRC, passing
  frames, responses with and without CRC inversion, response buffer fill.
  Assumes fcr_host_model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_crc_and_response_control_test;
  logic [7:0]  rx_data, fwd_data, resp_data, tx_data;
  logic [2:0]  cmd_req_type;
  logic        mclk, arst_n, rx_valid, rx_last, fwd_valid, fwd_last, cmd_valid;
  logic        cmd_is_read, crc_err, response_crc_invert, resp_valid, resp_last;
  logic        resp_ready, resp_busy, tx_valid, tx_last, tx_ready, stall, got;
  logic [31:0] rnd;
  logic [4:0]  eq[$];
  logic [8:0]  tq[$];
  int          mismatches, checks, cyc;

  fcr_top i_fcr_top (.mclk, .arst_n, .rx_data, .rx_valid, .rx_last, .fwd_data,
    .fwd_valid, .fwd_last, .cmd_valid, .cmd_req_type, .cmd_is_read, .crc_err,
    .response_crc_invert, .resp_data, .resp_valid, .resp_last, .resp_ready,
    .resp_busy, .tx_data, .tx_valid, .tx_last, .tx_ready);
  fcr_host_model i_fcr_host_model (.mclk, .arst_n, .stall, .tx_valid, .tx_ready, .got);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A corrupted frame flips one bit of the low CRC byte
  task automatic send_cmd(input logic [7:0] init, input logic bad);
    logic [7:0]  f[$];
    logic [15:0] c;
    logic [2:0]  rq;
    rnd = lfsr(rnd);
    f = '{init, 8'h00, 8'h02, 8'h0F, (init == 8'h80) ? 8'h0B : rnd[7:0]};
    c = 16'hFFFF;
    foreach (f[i])
      c = crc_upd(c, f[i]);
    if (init == 8'h80)
      chk("reference crc", c, 16'h29C0);
    f.push_back(c[7:0] ^ {7'h00, bad});
    f.push_back(c[15:8]);
    rq = init[6:4];
    if (bad)
      eq.push_back(5'h10);
    else if (init[7])
      eq.push_back({1'b0, (rq == 3'h0 || rq == 3'h2 || rq == 3'h4), rq});
    foreach (f[i])
    begin
      @(negedge mclk);
      rx_data  = f[i];
      rx_valid = 1'b1;
      rx_last  = (i == 6);
    end
  endtask

  task automatic rx_idle();
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_last  = 1'b0;
  endtask

  task automatic send_resp(input int n, input logic inv);
    logic [15:0] c;
    int          w;
    c = 16'hFFFF;
    @(negedge mclk);
    response_crc_invert = inv;
    for (int k = 0; k < n; k++)
    begin
      rnd        = lfsr(rnd);
      resp_data  = rnd[7:0];
      resp_valid = 1'b1;
      resp_last  = (k == n - 1);
      tq.push_back({1'b0, rnd[7:0]});
      c = crc_upd(c, rnd[7:0]);
      w = 0;
      while (resp_ready !== 1'b1 && w < 500)
      begin
        @(negedge mclk);
        w++;
      end
      chk("ready wait", {15'h0000, w >= 500}, 16'h0000);
      @(negedge mclk);
    end
    resp_valid = 1'b0;
    resp_last  = 1'b0;
    c = c ^ (inv ? 16'hFFFF : 16'h0000);
    tq.push_back({1'b0, c[7:0]});
    tq.push_back({1'b1, c[15:8]});
    w = 0;
    while (resp_busy !== 1'b0 && w < 500)
    begin
      @(negedge mclk);
      w++;
    end
    chk("busy wait", {15'h0000, w >= 500}, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // Watchers
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (arst_n && got)
    begin
      if (tq.size() == 0)
        chk("tx extra", {7'h00, tx_last, tx_data}, 16'hFFFF);
      else
        chk("tx byte", {7'h00, tx_last, tx_data}, {7'h00, tq.pop_front()});
    end
    if (arst_n && (cmd_valid || crc_err))
    begin
      if (eq.size() == 0)
        chk("result extra", {11'h000, crc_err, cmd_is_read, cmd_req_type}, 16'hFFFF);
      else
        chk("result", {11'h000, crc_err, cmd_valid ? {cmd_is_read, cmd_req_type} : 4'h0},
            {11'h000, eq.pop_front()});
    end
  end

  // Whole run needs a few hundred cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    rnd                 = 32'hD7B1;
    arst_n              = 1'b0;
    rx_data             = 8'h00;
    rx_valid            = 1'b0;
    rx_last             = 1'b0;
    response_crc_invert = 1'b0;
    resp_data           = 8'h00;
    resp_valid          = 1'b0;
    resp_last           = 1'b0;
    stall               = 1'b0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      send_cmd({1'b1, r[2:0], 4'h0}, 1'b0);
      rx_idle();
      if (r == 0 || r == 2 || r == 4)
        send_resp(5, r == 4);
    end
    send_cmd(8'hB0, 1'b0);
    send_cmd(8'hC0, 1'b1);
    send_cmd(8'h20, 1'b0);
    rx_idle();
    repeat (4) @(negedge mclk);
    chk("busy after bad read", {15'h0000, resp_busy}, 16'h0000);
    stall = 1'b1;
    send_cmd(8'hA0, 1'b0);
    rx_idle();
    fork
      send_resp(20, 1'b1);
    join_none
    // A good read during a response still reports but opens no frame
    send_cmd(8'hC0, 1'b0);
    rx_idle();
    repeat (52) @(negedge mclk);
    chk("ready when full", {15'h0000, resp_ready}, 16'h0000);
    chk("busy when full", {15'h0000, resp_busy}, 16'h0001);
    stall = 1'b0;
    wait fork;
    repeat (100) @(negedge mclk);
    chk("tx left", 16'(tq.size()), 16'h0000);
    chk("results left", 16'(eq.size()), 16'h0000);
    test_done();
  end
endmodule

`default_nettype wire
